// file: core/tcc_timer.v
// Timer capture/compare unit: 16-bit free-running count, three captures,
// four compares, one shared capture/compare channel and port pin control.
// Assumes a single 25 MHz bus clock and a simple strobed 8-bit register port.
//
// Summary of operation
// - Prescaler divides bus clock by 1/4/8/16.
// - Prescale bits writable once, first 64 cycles.
// - Sixteen-bit read-only count, reset clears, wraps.
// - Overflow flag set on all-ones to zero.
// - Overflow flag plus enable requests interrupt.
// - Reading the count never disturbs it.
// - Capture registers latch count on edge.
// - Two-bit edge select per capture channel.
// - Shared channel is compare unless function set.
// - Shared register ignores writes while capturing.
// - Own pin writes trigger shared channel capture.
// - Capture edge can raise interrupt request.
// - Compare registers read/write, reset all ones.
// - Compare once per count step, equality sets flag.
// - Compare interrupt only when mask bit set.
// - Pin action on every match, flag regardless.
// - Action codes: off, toggle, low, high.
// - First compare mask drives pins seven..three.
// - First compare copies data bits to pins.
// - Enabled compare forces pin as output.
// - Force bits apply action, no flag set.
// - Low three force/mask bits read zero.
// - Flags cleared only by writing one.
`timescale 1ns/1ps
`include "tcc_map.vh"

module tcc_timer (
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        RESETN,
  // Register port
  input  wire [15:0] ADDR,
  input  wire [7:0]  WR_DATA,
  input  wire        WR_STB,
  input  wire        RD_STB,
  output reg  [7:0]  RD_DATA,
  // Port pins, enable low while driving
  input  wire [7:0]  PORT_IN,
  output reg  [7:0]  PORT_OUT,
  output reg  [7:0]  PORT_OE_N,
  // Interrupt request level
  output reg         IRQ_REQ
);

  // Pin level after a compare action
  function act_level;
    input [1:0] mode;
    input       cur;
    begin
      case (mode)
        2'h1:    act_level = ~cur;
        2'h2:    act_level = 1'b0;
        2'h3:    act_level = 1'b1;
        default: act_level = cur;
      endcase
    end
  endfunction

  // Selected edge between two samples
  function edge_hit;
    input [1:0] sel;
    input       prev;
    input       now;
    begin
      edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
    end
  endfunction

  // High byte address of the idx-th 16-bit register from base
  function [15:0] word_addr;
    input [15:0] base;
    input [2:0]  idx;
    begin
      word_addr = base + {12'h000, idx, 1'b0};
    end
  endfunction

  // Prescale decode to a mask on the divider count
  function [3:0] div_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'h1:    div_mask = 4'h3;
        2'h2:    div_mask = 4'h7;
        2'h3:    div_mask = 4'hf;
        default: div_mask = 4'h0;
      endcase
    end
  endfunction

  // Counter and prescaler state
  reg  [15:0] count_reg;
  reg  [3:0]  presc_div_reg;
  reg         count_new_reg;
  reg  [1:0]  prescale_sel_reg;
  reg  [6:0]  init_cnt_reg;
  reg         presc_lock_reg;
  reg  [7:0]  count_lo_buf_reg;
  reg         hi_read_reg;
  // Control and status registers
  reg  [3:0]  timer_mask_two_reg;
  reg         overflow_flag_reg;
  reg  [7:0]  timer_mask_one_reg;
  reg  [7:0]  timer_flags_one_reg;
  reg  [7:0]  compare_action_control_reg;
  reg  [7:0]  capture_edge_control_reg;
  reg         shared_channel_function_reg;
  reg  [7:0]  port_direction_reg;
  reg  [4:0]  compare1_pin_mask_reg;
  reg  [4:0]  compare1_pin_data_reg;
  // Compare words 0..3, shared channel at index 4
  reg  [15:0] cmp_reg [0:4];
  // Capture words 0..2, shared capture at index 3
  reg  [15:0] cap_reg [0:3];
  // Pin synchronisers and edge history
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg  [3:0]  prev_reg;

  // Combinational results
  reg         tick;
  reg  [4:0]  match;
  reg  [4:0]  go;
  reg  [3:0]  lvl;
  reg  [3:0]  cap_hit;
  reg  [7:0]  flags_set;
  reg  [7:0]  port_next;
  reg  [7:0]  drive_next;
  reg  [7:0]  rd_next;
  reg  [1:0]  field;
  reg  [4:0]  force_bits;
  integer     k, k_rd, k_wr, k_cap;
  wire wr_force = WR_STB && (ADDR == `TCC_FORCE);
  wire rd_hi    = RD_STB && (ADDR == `TCC_COUNT_HI);

  always @* begin
    tick = ((presc_div_reg & div_mask(prescale_sel_reg)) ==
            div_mask(prescale_sel_reg));
  end

  // Matches, captures, pin actions and flag sets
  always @* begin
    match = 5'h00;
    cap_hit = 4'h0;
    field = 2'h0;
    for (k = 0; k < 5; k = k + 1) begin
      match[k] = count_new_reg && (count_reg == cmp_reg[k]);
    end
    // shared channel compares only in compare mode
    match[4] = match[4] & ~shared_channel_function_reg;
    // force bits, high bit is the first channel
    force_bits = wr_force ? WR_DATA[7:3] : 5'h00;
    for (k = 0; k < 5; k = k + 1) begin
      go[k] = match[k] | force_bits[4 - k];
    end
    go[4] = go[4] & ~shared_channel_function_reg;
    // pin three follows own output when its direction bit is set
    lvl[2:0] = sync2_reg[2:0];
    lvl[3] = port_direction_reg[3] ? PORT_OUT[3] : sync2_reg[3];
    cap_hit[0] = edge_hit(capture_edge_control_reg[5:4], prev_reg[0], lvl[0]);
    cap_hit[1] = edge_hit(capture_edge_control_reg[3:2], prev_reg[1], lvl[1]);
    cap_hit[2] = edge_hit(capture_edge_control_reg[1:0], prev_reg[2], lvl[2]);
    cap_hit[3] = edge_hit(capture_edge_control_reg[7:6], prev_reg[3], lvl[3]) &
                 shared_channel_function_reg;
    flags_set = {match[0], match[1], match[2], match[3],
                 shared_channel_function_reg ? cap_hit[3] : match[4],
                 cap_hit[0], cap_hit[1], cap_hit[2]};
    // Software port write first, then compare actions on top
    port_next = (WR_STB && ADDR == `TCC_PORT_DATA) ? WR_DATA : PORT_OUT;
    drive_next = port_direction_reg;
    for (k = 1; k < 5; k = k + 1) begin
      field = compare_action_control_reg[(9 - 2 * k) -: 2];
      // act on every match, flag state ignored
      if (go[k]) begin
        port_next[7 - k] = act_level(field, port_next[7 - k]);
      end
      if (field != 2'h0 && !(k == 4 && shared_channel_function_reg)) begin
        drive_next[7 - k] = 1'b1;
      end
    end
    // first compare mask selects pins seven..three
    for (k = 0; k < 5; k = k + 1) begin
      if (compare1_pin_mask_reg[k]) begin
        drive_next[k + 3] = 1'b1;
        // copy data bit on first compare
        if (go[0]) begin
          port_next[k + 3] = compare1_pin_data_reg[k];
        end
      end
    end
  end

  // Read data multiplexer, unmapped addresses read zero
  always @* begin
    rd_next = 8'h00;
    case (ADDR)
      `TCC_PORT_DATA: rd_next = PORT_OUT;
      `TCC_PORT_DIR:  rd_next = port_direction_reg;
      // low bits of mask read zero, force reads zero
      `TCC_C1_MASK:   rd_next = {compare1_pin_mask_reg, 3'h0};
      `TCC_C1_DATA:   rd_next = {compare1_pin_data_reg, 3'h0};
      `TCC_COUNT_HI:  rd_next = count_reg[15:8];
      `TCC_COUNT_LO:  rd_next = hi_read_reg ? count_lo_buf_reg : count_reg[7:0];
      `TCC_ACT_CTL:   rd_next = compare_action_control_reg;
      `TCC_EDGE_CTL:  rd_next = capture_edge_control_reg;
      `TCC_MASK_ONE:  rd_next = timer_mask_one_reg;
      `TCC_FLAGS_ONE: rd_next = timer_flags_one_reg;
      `TCC_MASK_TWO:  rd_next = {timer_mask_two_reg, 2'h0, prescale_sel_reg};
      `TCC_FLAGS_TWO: rd_next = {overflow_flag_reg, 7'h00};
      `TCC_ACC_CTL:   rd_next = {5'h00, shared_channel_function_reg, 2'h0};
      default: begin
        for (k_rd = 0; k_rd < 5; k_rd = k_rd + 1) begin
          if (ADDR == word_addr(`TCC_CMP_BASE, k_rd[2:0])) begin
            rd_next = cmp_reg[k_rd][15:8];
          end
          if (ADDR == word_addr(`TCC_CMP_BASE, k_rd[2:0]) + 16'h0001) begin
            rd_next = cmp_reg[k_rd][7:0];
          end
        end
        for (k_rd = 0; k_rd < 3; k_rd = k_rd + 1) begin
          if (ADDR == word_addr(`TCC_CAP_BASE, k_rd[2:0])) begin
            rd_next = cap_reg[k_rd][15:8];
          end
          if (ADDR == word_addr(`TCC_CAP_BASE, k_rd[2:0]) + 16'h0001) begin
            rd_next = cap_reg[k_rd][7:0];
          end
        end
        // Shared word shows capture value in capture mode
        if (shared_channel_function_reg && ADDR == `TCC_SHARED_HI) begin
          rd_next = cap_reg[3][15:8];
        end
        if (shared_channel_function_reg && ADDR == `TCC_SHARED_HI + 16'h0001) begin
          rd_next = cap_reg[3][7:0];
        end
      end
    endcase
  end

  // Counter, prescaler and overflow
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      count_reg <= `TCC_COUNT_RESET;
      presc_div_reg <= 4'h0;
      count_new_reg <= 1'b0;
      overflow_flag_reg <= 1'b0;
      count_lo_buf_reg <= 8'h00;
      hi_read_reg <= 1'b0;
    end else begin
      presc_div_reg <= presc_div_reg + 4'h1;
      count_new_reg <= tick;
      if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
      if (tick && count_reg == `TCC_COUNT_TOP) begin
        overflow_flag_reg <= 1'b1;
      end else if (WR_STB && ADDR == `TCC_FLAGS_TWO && WR_DATA[`TCC_OVF_BIT]) begin
        overflow_flag_reg <= 1'b0;
      end
      // Low byte held for a following low read
      if (rd_hi) begin
        count_lo_buf_reg <= count_reg[7:0];
      end
      if (RD_STB) begin
        hi_read_reg <= rd_hi;
      end
    end
  end

  // Prescale select and its write window
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      prescale_sel_reg <= 2'h0;
      init_cnt_reg <= 7'h00;
      presc_lock_reg <= 1'b0;
    end else begin
      if (init_cnt_reg != `TCC_PRESC_WINDOW) begin
        init_cnt_reg <= init_cnt_reg + 7'h01;
      end
      if (WR_STB && ADDR == `TCC_MASK_TWO && !presc_lock_reg &&
          init_cnt_reg != `TCC_PRESC_WINDOW) begin
        prescale_sel_reg <= WR_DATA[1:0];
        presc_lock_reg <= 1'b1;
      end
    end
  end

  // Control registers and compare words
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      timer_mask_two_reg <= 4'h0;
      timer_mask_one_reg <= `TCC_BYTE_RESET;
      compare_action_control_reg <= `TCC_BYTE_RESET;
      capture_edge_control_reg <= `TCC_BYTE_RESET;
      shared_channel_function_reg <= 1'b0;
      port_direction_reg <= `TCC_BYTE_RESET;
      compare1_pin_mask_reg <= 5'h00;
      compare1_pin_data_reg <= 5'h00;
      // compare words start at all ones
      for (k_wr = 0; k_wr < 5; k_wr = k_wr + 1) begin
        cmp_reg[k_wr] <= `TCC_CMP_RESET;
      end
    end else if (WR_STB) begin
      case (ADDR)
        `TCC_MASK_TWO:  timer_mask_two_reg <= WR_DATA[7:4];
        `TCC_MASK_ONE:  timer_mask_one_reg <= WR_DATA;
        `TCC_ACT_CTL:   compare_action_control_reg <= WR_DATA;
        `TCC_EDGE_CTL:  capture_edge_control_reg <= WR_DATA;
        `TCC_ACC_CTL:   shared_channel_function_reg <= WR_DATA[`TCC_SHARED_FN_BIT];
        `TCC_PORT_DIR:  port_direction_reg <= WR_DATA;
        `TCC_C1_MASK:   compare1_pin_mask_reg <= WR_DATA[7:3];
        `TCC_C1_DATA:   compare1_pin_data_reg <= WR_DATA[7:3];
        default: begin
          for (k_wr = 0; k_wr < 5; k_wr = k_wr + 1) begin
            if (!(k_wr == 4 && shared_channel_function_reg)) begin
              if (ADDR == word_addr(`TCC_CMP_BASE, k_wr[2:0])) begin
                cmp_reg[k_wr][15:8] <= WR_DATA;
              end
              if (ADDR == word_addr(`TCC_CMP_BASE, k_wr[2:0]) + 16'h0001) begin
                cmp_reg[k_wr][7:0] <= WR_DATA;
              end
            end
          end
        end
      endcase
    end
  end

  // Flags: a hardware set in the clear cycle survives
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      timer_flags_one_reg <= `TCC_BYTE_RESET;
    end else if (WR_STB && ADDR == `TCC_FLAGS_ONE) begin
      timer_flags_one_reg <= (timer_flags_one_reg & ~WR_DATA) | flags_set;
    end else begin
      // equality or edge sets the flag
      timer_flags_one_reg <= timer_flags_one_reg | flags_set;
    end
  end

  // capture words have no reset, latch on edge
  always @(posedge CLK_SYS) begin
    for (k_cap = 0; k_cap < 4; k_cap = k_cap + 1) begin
      if (cap_hit[k_cap]) begin
        cap_reg[k_cap] <= count_reg;
      end
    end
  end

  // two-stage synchroniser, edge history from second stage
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= PORT_IN[3:0];
      sync2_reg <= sync1_reg;
      prev_reg <= lvl;
    end
  end

  // Pins, read data and interrupt request, all registered
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PORT_OUT <= 8'h00;
      PORT_OE_N <= 8'hff;
      RD_DATA <= 8'h00;
      IRQ_REQ <= 1'b0;
    end else begin
      PORT_OUT <= port_next;
      PORT_OE_N <= ~drive_next;
      // Data stand only in the cycle after the strobe
      RD_DATA <= RD_STB ? rd_next : 8'h00;
      IRQ_REQ <= (|(timer_flags_one_reg & timer_mask_one_reg)) |
                 (overflow_flag_reg & timer_mask_two_reg[3]);
    end
  end

endmodule // tcc_timer

// file: core/tcc_map.vh
// Register map, field positions and reset values of the timer unit.
// Assumes an 8-bit register port with 16-bit byte addresses.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// Byte offsets of the registers
`define TCC_PORT_DATA      16'h1000
`define TCC_PORT_DIR       16'h1001
`define TCC_FORCE          16'h100b
`define TCC_C1_MASK        16'h100c
`define TCC_C1_DATA        16'h100d
`define TCC_COUNT_HI       16'h100e
`define TCC_COUNT_LO       16'h100f
`define TCC_CAP_BASE       16'h1010
`define TCC_CMP_BASE       16'h1016
`define TCC_SHARED_HI      16'h101e
`define TCC_ACT_CTL        16'h1020
`define TCC_EDGE_CTL       16'h1021
`define TCC_MASK_ONE       16'h1022
`define TCC_FLAGS_ONE      16'h1023
`define TCC_MASK_TWO       16'h1024
`define TCC_FLAGS_TWO      16'h1025
`define TCC_ACC_CTL        16'h1026

// Field positions
`define TCC_SHARED_FN_BIT  2
`define TCC_OVF_BIT        7
`define TCC_SHARED_FLAG    3

// Reset values
`define TCC_CMP_RESET      16'hffff
`define TCC_BYTE_RESET     8'h00
`define TCC_COUNT_RESET    16'h0000
`define TCC_COUNT_TOP      16'hffff

// Prescaler select window after reset, in bus clocks
`define TCC_PRESC_WINDOW   7'h40

`endif

// file: verification/tcc_timer_asserts.sv
// Port-level assertions for the timer unit.
// Assumes binding into tcc_timer; config writes are shadowed here.
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_chk (
  // Clock and reset
  input wire        CLK_SYS,
  input wire        RESETN,
  // Register port
  input wire [15:0] ADDR,
  input wire [7:0]  WR_DATA,
  input wire        WR_STB,
  input wire        RD_STB,
  input wire [7:0]  RD_DATA,
  // Pins and request
  input wire [7:0]  PORT_OUT,
  input wire [7:0]  PORT_OE_N,
  input wire        IRQ_REQ
);
  reg  [7:0] dir_reg;
  reg  [7:0] act_reg;
  reg  [7:0] msk_reg;
  reg  [7:0] m1_reg;
  reg        m2_reg;
  // First compare owns pin 6 when its mask bit is set
  wire       frc6 = WR_STB && ADDR == `TCC_FORCE && WR_DATA[6] && act_reg[7] && !msk_reg[6];
  wire       rd_frc = RD_STB && ADDR == `TCC_FORCE;
  wire       rd_msk = RD_STB && ADDR == `TCC_C1_MASK;

  // Shadow config, as no internal state is visible here
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dir_reg <= 8'h00;
      act_reg <= 8'h00;
      msk_reg <= 8'h00;
      m1_reg  <= 8'h00;
      m2_reg  <= 1'b0;
    end else if (WR_STB) begin
      if (ADDR == `TCC_PORT_DIR) dir_reg <= WR_DATA;
      if (ADDR == `TCC_ACT_CTL) act_reg <= WR_DATA;
      if (ADDR == `TCC_C1_MASK) msk_reg <= WR_DATA;
      if (ADDR == `TCC_MASK_ONE) m1_reg <= WR_DATA;
      if (ADDR == `TCC_MASK_TWO) m2_reg <= WR_DATA[7];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // Port rules
  a_read_idle_zero: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
    else $error("read data not zero outside read cycle");
  a_force_reads_zero: assert property ($past(rd_frc) |-> RD_DATA == 8'h00)
    else $error("force register read not zero");
  a_mask_low_zero: assert property ($past(rd_msk) |-> RD_DATA[2:0] == 3'h0)
    else $error("mask low bits not zero");
  a_low_pins_dir: assert property (PORT_OE_N[2:0] == ~$past(dir_reg[2:0]))
    else $error("low pin enables do not follow direction");
  a_pin7_forced: assert property (PORT_OE_N[7] == ~($past(dir_reg[7]) | $past(msk_reg[7])))
    else $error("pin 7 enable wrong");
  a_pin6_forced: assert property ($past(act_reg[7:6]) != 2'b00 |-> !PORT_OE_N[6])
    else $error("pin 6 not driven under compare");
  a_force_action: assert property ($past(frc6) |-> PORT_OUT[6] == $past(act_reg[6]))
    else $error("forced level on pin 6 wrong");
  a_irq_masked: assert property ($past(m1_reg) == 8'h00 && !$past(m2_reg) |-> !IRQ_REQ)
    else $error("request raised with all masks clear");
endmodule // tcc_chk

bind tcc_timer tcc_chk u_tcc_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .PORT_OUT(PORT_OUT), .PORT_OE_N(PORT_OE_N), .IRQ_REQ(IRQ_REQ));

// file: verification/tcc_pins.sv
// Far-side pin model: event sources on pins 3..0, pull-ups on 7..4.
// Assumes the bench moves src_lvl just after a clock edge.
`timescale 1ns/1ps
module tcc_pins (
  // From the design
  input  wire [7:0] PORT_OUT,
  input  wire [7:0] PORT_OE_N,
  // Wanted source levels
  input  wire [3:0] src_lvl,
  // Wire level back
  output wire [7:0] PORT_IN
);
  wire [7:0] src = {4'hf, src_lvl};
  // driven pin loops
  // A driven pin reads its own level, so port writes make edges
  assign PORT_IN = (~PORT_OE_N & PORT_OUT) | (PORT_OE_N & src);
endmodule // tcc_pins

// file: verification/test_timer_capture_compare_unit.sv
// Self-checking bench for the timer unit with its pin model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`include "tcc_map.vh"
module test_timer_capture_compare_unit;
  reg         clk_sys = 1'b0;
  reg         resetn = 1'b0;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wr_data = 8'h00;
  reg         wr_stb = 1'b0;
  reg         rd_stb = 1'b0;
  reg  [3:0]  src_lvl = 4'h0;
  wire [7:0]  rd_data;
  wire [7:0]  port_in;
  wire [7:0]  port_out;
  wire [7:0]  port_oe_n;
  wire        irq_req;
  integer     num_errors = 0;
  integer     tests_run = 0;
  integer     cycles = 0;

  tcc_timer u_tcc_timer (.CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr),
    .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .PORT_IN(port_in), .PORT_OUT(port_out), .PORT_OE_N(port_oe_n), .IRQ_REQ(irq_req));
  tcc_pins u_tcc_pins (.PORT_OUT(port_out), .PORT_OE_N(port_oe_n), .src_lvl(src_lvl),
    .PORT_IN(port_in));

  // 40 ns bus clock
  always #20 clk_sys = ~clk_sys;
  // Ceiling; the overflow wait alone is up to 65536 cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles > 90000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    begin
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
    end
  endtask
  // Data stands one cycle only, so it is taken right after that edge
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 d = rd_data;
    end
  endtask
  task rc(input [8*10-1:0] nm, input [15:0] a, input [7:0] e);
    reg [7:0] v;
    begin
      rd(a, v);
      chk(nm, e, v);
    end
  endtask
  task do_reset;
    begin
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
    end
  endtask
  // Arm a 16-bit compare 100 counts ahead, then wait past it
  task aim(input [15:0] a);
    reg [15:0] t;
    begin
      rd(`TCC_COUNT_HI, t[15:8]);
      rd(`TCC_COUNT_LO, t[7:0]);
      t = t + 16'd100;
      wr(a, t[15:8]);
      wr(a + 16'd1, t[7:0]);
      repeat (100) @(posedge clk_sys);
    end
  endtask

  // Each divide code after its own reset; reads 48 clocks apart
  task t_presc;
    reg [7:0] a;
    reg [7:0] b;
    integer k;
    begin
      for (k = 3; k >= 0; k = k - 1) begin
        do_reset;
        wr(`TCC_MASK_TWO, 8'h80 | k[7:0]);
        wr(`TCC_MASK_TWO, 8'h82);
        rc("presc", `TCC_MASK_TWO, 8'h80 | k[7:0]);
        rd(`TCC_COUNT_LO, a);
        repeat (46) @(posedge clk_sys);
        rd(`TCC_COUNT_LO, b);
        chk("step", 8'd48 >> (k == 0 ? 0 : k + 1), b - a);
      end
    end
  endtask
  task t_reset;
    reg [7:0] a;
    reg [7:0] b;
    begin
      rc("mask1", `TCC_C1_MASK, 8'h00);
      rc("edge", `TCC_EDGE_CTL, 8'h00);
      rc("cmp1", `TCC_CMP_BASE + 16'd1, 8'hff);
      rc("shared", `TCC_SHARED_HI, 8'hff);
      rc("force", `TCC_FORCE, 8'h00);
      rc("unmapped", 16'h1030, 8'h00);
      wr(`TCC_C1_MASK, 8'hff);
      rc("masklow", `TCC_C1_MASK, 8'hf8);
      wr(`TCC_C1_MASK, 8'h00);
      wr(`TCC_COUNT_HI, 8'h55);
      rc("count", `TCC_COUNT_HI, 8'h00);
      rd(`TCC_COUNT_LO, a);
      rd(`TCC_COUNT_HI, b);
      rd(`TCC_COUNT_LO, b);
      // Both low reads follow a high read, so both give latched bytes
      chk("latch", a + 8'd4, b);
    end
  endtask
  // Toggle twice with the flag left set, then force high, then low
  task t_cmp;
    integer j;
    begin
      wr(`TCC_ACT_CTL, 8'h40);
      wr(`TCC_MASK_ONE, 8'h40);
      for (j = 0; j < 2; j = j + 1) begin
        aim(`TCC_CMP_BASE + 16'd2);
        chk("toggle", {7'h0, j == 0}, {7'h0, port_out[6]});
      end
      rc("flag", `TCC_FLAGS_ONE, 8'h40);
      chk("irq", 8'h01, {7'h0, irq_req});
      wr(`TCC_FLAGS_ONE, 8'hbf);
      rc("noclear", `TCC_FLAGS_ONE, 8'h40);
      wr(`TCC_FLAGS_ONE, 8'h40);
      rc("clear", `TCC_FLAGS_ONE, 8'h00);
      chk("irqoff", 8'h00, {7'h0, irq_req});
      wr(`TCC_MASK_ONE, 8'h00);
      // Force is only used with fixed levels, never with toggle
      for (j = 0; j < 2; j = j + 1) begin
        wr(`TCC_ACT_CTL, j == 0 ? 8'hc0 : 8'h80);
        wr(`TCC_FORCE, 8'h40);
        #1;
        chk("force", {7'h0, j == 0}, {7'h0, port_out[6]});
      end
      rc("noflag", `TCC_FLAGS_ONE, 8'h00);
      wr(`TCC_C1_MASK, 8'h88);
      wr(`TCC_C1_DATA, 8'h88);
      aim(`TCC_CMP_BASE);
      chk("oc1pins", 8'h88, port_out & 8'hc8);
      chk("oc1oe", 8'h00, port_oe_n & 8'h88);
      wr(`TCC_C1_MASK, 8'h00);
      wr(`TCC_FLAGS_ONE, 8'h80);
    end
  endtask
  // Edge codes on pin 1, then a timed capture on pin 0
  task t_cap;
    reg [7:0] a;
    reg [7:0] b;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(`TCC_EDGE_CTL, {4'h0, k[1:0], 2'b00});
        @(posedge clk_sys) src_lvl[1] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rc("rise", `TCC_FLAGS_ONE, {6'h0, k[0], 1'b0});
        wr(`TCC_FLAGS_ONE, 8'h02);
        @(posedge clk_sys) src_lvl[1] <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rc("fall", `TCC_FLAGS_ONE, {6'h0, k[1], 1'b0});
        wr(`TCC_FLAGS_ONE, 8'h02);
      end
      wr(`TCC_EDGE_CTL, 8'h10);
      rd(`TCC_COUNT_LO, a);
      @(posedge clk_sys) src_lvl[0] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd(`TCC_CAP_BASE + 16'd1, b);
      chk("captime", a + 8'd4, b);
      rc("capflag", `TCC_FLAGS_ONE, 8'h04);
      wr(`TCC_FLAGS_ONE, 8'h04);
    end
  endtask
  task t_sh;
    begin
      wr(`TCC_SHARED_HI, 8'h12);
      rc("sharedwr", `TCC_SHARED_HI, 8'h12);
      wr(`TCC_ACC_CTL, 8'h04);
      wr(`TCC_SHARED_HI, 8'h34);
      wr(`TCC_PORT_DIR, 8'h08);
      wr(`TCC_EDGE_CTL, 8'h40);
      // Pin 3 may already be high from the first compare
      wr(`TCC_PORT_DATA, 8'h00);
      wr(`TCC_PORT_DATA, 8'h08);
      repeat (5) @(posedge clk_sys);
      rc("selfcap", `TCC_FLAGS_ONE, 8'h08);
      // Capture mode shows the capture word, so look in compare mode
      wr(`TCC_ACC_CTL, 8'h00);
      rc("sharedro", `TCC_SHARED_HI, 8'h12);
    end
  endtask
  task t_ovf;
    integer i;
    begin
      rc("early", `TCC_FLAGS_TWO, 8'h00);
      i = 0;
      while (irq_req !== 1'b1 && i < 70000) begin
        @(posedge clk_sys);
        i = i + 1;
      end
      rc("wrap", `TCC_COUNT_HI, 8'h00);
      rc("ovf", `TCC_FLAGS_TWO, 8'h80);
      wr(`TCC_FLAGS_TWO, 8'h7f);
      rc("ovfkeep", `TCC_FLAGS_TWO, 8'h80);
      wr(`TCC_FLAGS_TWO, 8'h80);
      // Request follows the flag one cycle later
      repeat (2) @(posedge clk_sys);
      chk("ovfirq", 8'h00, {7'h0, irq_req});
    end
  endtask

  initial begin
    t_presc;
    t_reset;
    t_cmp;
    t_cap;
    t_sh;
    t_ovf;
    tally_and_finish;
  end
endmodule // test_timer_capture_compare_unit
